// File: rtl/ttc_map.svh
`ifndef TTC_MAP_SVH
`define TTC_MAP_SVH

// ****************************************************************
// Register indices; the byte address of each word is four times its index.
// ****************************************************************
`define TTC_ADDR_W          14
`define TTC_IDX_W           12
`define TTC_IDX_REVISION    12'hA00
`define TTC_IDX_SCRATCH     12'hA01
`define TTC_IDX_NAME0       12'hA02
`define TTC_IDX_NAME1       12'hA03
`define TTC_IDX_NAME2       12'hA04
`define TTC_IDX_PERIOD      12'hA05
`define TTC_IDX_RSVD_FIRST  12'hA06
`define TTC_IDX_RSVD_LAST   12'hA09
`define TTC_IDX_EXTRA       12'hA0A
`define TTC_IDX_ASYM        12'hA0B
`define TTC_IDX_SERDES      12'hA0C

// ****************************************************************
// Identification values; all arbitrary, chosen to name no real part.
// ****************************************************************
`define TTC_REVISION_VALUE  32'h0000_0001
`define TTC_NAME0_VALUE     32'h5453_434F
`define TTC_NAME1_VALUE     32'h5252_3030
`define TTC_NAME2_VALUE     32'h3030_3031

// ****************************************************************
// Field layout and reset values.
// ****************************************************************
`define TTC_FRAC_W          16
`define TTC_PERIOD_W        20
`define TTC_ASYM_W          19
`define TTC_MAG_W           17
`define TTC_ASYM_EN_BIT     18
`define TTC_ASYM_SUB_BIT    17
`define TTC_DELAY_W         35
`define TTC_WORD_RESET      32'h0000_0000
`define TTC_ASYM_RESET      19'h0_0000
`define TTC_MAC_CLK_KHZ     64'd312500
`define TTC_PERIOD_RESET    (20'(((64'd1000000) << 16) / `TTC_MAC_CLK_KHZ))

`endif

// File: rtl/ttc_pkg.sv
`default_nettype none

package ttc_pkg;

	typedef logic [31:0] ttc_word_t;

	typedef enum logic [1:0] {
		TTC_RESP_OKAY   = 2'b00,
		TTC_RESP_SLVERR = 2'b10
	} ttc_resp_t;

endpackage : ttc_pkg

`default_nettype wire

// File: rtl/ttc_regs.sv
// Design decision made here: register access over AXI4-Lite.

`include "ttc_map.svh"

`default_nettype none

module ttc_regs (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [`TTC_ADDR_W-1:0]        awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	input  wire logic [`TTC_ADDR_W-1:0]        araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	output logic [`TTC_PERIOD_W-1:0]           mac_clock_period,
	output logic [31:0]                        user_extra_latency,
	output logic [31:0]                        serialiser_latency,
	output logic                               asym_enable,
	output logic                               asym_subtract,
	output logic [`TTC_MAG_W-1:0]              asym_magnitude,
	output logic signed [`TTC_DELAY_W-1:0]     asym_offset,
	output logic signed [`TTC_DELAY_W-1:0]     fixed_delay
);

	// ****************************************************************
	// Helpers
	// ****************************************************************

	function automatic ttc_pkg::ttc_word_t ttc_merge(
		input ttc_pkg::ttc_word_t old_word,
		input ttc_pkg::ttc_word_t new_word,
		input logic [3:0]         strb
	);
		ttc_pkg::ttc_word_t merged;
		merged = old_word;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merged[b*8 +: 8] = new_word[b*8 +: 8];
			end
		end
		return merged;
	endfunction : ttc_merge

	// Reserved words count as mapped so they answer OKAY, not an error.
	function automatic logic ttc_mapped(
		input logic [`TTC_IDX_W-1:0] idx
	);
		return (idx >= `TTC_IDX_REVISION) && (idx <= `TTC_IDX_SERDES);
	endfunction : ttc_mapped

	// Magnitude is whole nanoseconds, so it is shifted into 16.16 form.
	function automatic logic signed [`TTC_DELAY_W-1:0] ttc_asym(
		input logic [`TTC_ASYM_W-1:0] word
	);
		logic signed [`TTC_DELAY_W-1:0] mag;
		mag = `TTC_DELAY_W'({word[`TTC_MAG_W-1:0], `TTC_FRAC_W'(0)});
		if (!word[`TTC_ASYM_EN_BIT]) begin
			return '0;
		end
		if (word[`TTC_ASYM_SUB_BIT]) begin
			return -mag;
		end
		return mag;
	endfunction : ttc_asym

	// ****************************************************************
	// Write channel
	// ****************************************************************

	logic                     aw_held;
	logic [`TTC_IDX_W-1:0]    aw_idx;
	logic                     w_held;
	ttc_pkg::ttc_word_t       w_data;
	logic [3:0]               w_strb;
	logic                     next_aw_held;
	logic [`TTC_IDX_W-1:0]    next_aw_idx;
	logic                     next_w_held;
	ttc_pkg::ttc_word_t       next_w_data;
	logic [3:0]               next_w_strb;
	logic                     next_awready;
	logic                     next_wready;
	logic                     next_bvalid;
	logic [1:0]               next_bresp;
	logic                     do_write;

	ttc_pkg::ttc_word_t       scratch_test_word;
	ttc_pkg::ttc_word_t       next_scratch;
	logic [`TTC_PERIOD_W-1:0] next_period;
	ttc_pkg::ttc_word_t       next_extra;
	logic [`TTC_ASYM_W-1:0]   asymmetry_adjust;
	logic [`TTC_ASYM_W-1:0]   next_asym;
	ttc_pkg::ttc_word_t       next_serdes;
	ttc_pkg::ttc_word_t       period_word;

	assign period_word = 32'(mac_clock_period);

	always_comb begin
		next_aw_held = aw_held;
		next_aw_idx  = aw_idx;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_scratch = scratch_test_word;
		next_period  = mac_clock_period;
		next_extra   = user_extra_latency;
		next_asym    = asymmetry_adjust;
		next_serdes  = serialiser_latency;
		do_write     = aw_held && w_held && !bvalid;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_aw_idx  = awaddr[`TTC_ADDR_W-1:2];
		end
		if (wvalid && wready) begin
			next_w_held = 1'b1;
			next_w_data = wdata;
			next_w_strb = wstrb;
		end
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = ttc_mapped(aw_idx) ? ttc_pkg::TTC_RESP_OKAY : ttc_pkg::TTC_RESP_SLVERR;
			// Identification and reserved words fall through and keep nothing.
			unique case (aw_idx)
				`TTC_IDX_SCRATCH: begin
					next_scratch = ttc_merge(scratch_test_word, w_data, w_strb);
				end
				`TTC_IDX_PERIOD: begin
					next_period = `TTC_PERIOD_W'(ttc_merge(period_word, w_data, w_strb));
				end
				`TTC_IDX_EXTRA: begin
					next_extra = ttc_merge(user_extra_latency, w_data, w_strb);
				end
				`TTC_IDX_ASYM: begin
					next_asym = `TTC_ASYM_W'(ttc_merge(32'(asymmetry_adjust), w_data, w_strb));
				end
				`TTC_IDX_SERDES: begin
					next_serdes = ttc_merge(serialiser_latency, w_data, w_strb);
				end
				default: begin
					next_scratch = scratch_test_word;
				end
			endcase
		end
		next_awready = !next_aw_held;
		next_wready  = !next_w_held;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held            <= 1'b0;
			aw_idx             <= '0;
			w_held             <= 1'b0;
			w_data             <= `TTC_WORD_RESET;
			w_strb             <= 4'h0;
			awready            <= 1'b1;
			wready             <= 1'b1;
			bvalid             <= 1'b0;
			bresp              <= ttc_pkg::TTC_RESP_OKAY;
			scratch_test_word  <= `TTC_WORD_RESET;
			mac_clock_period   <= `TTC_PERIOD_RESET;
			user_extra_latency <= `TTC_WORD_RESET;
			asymmetry_adjust   <= `TTC_ASYM_RESET;
			serialiser_latency <= `TTC_WORD_RESET;
		end else begin
			aw_held            <= next_aw_held;
			aw_idx             <= next_aw_idx;
			w_held             <= next_w_held;
			w_data             <= next_w_data;
			w_strb             <= next_w_strb;
			awready            <= next_awready;
			wready             <= next_wready;
			bvalid             <= next_bvalid;
			bresp              <= next_bresp;
			scratch_test_word  <= next_scratch;
			mac_clock_period   <= next_period;
			user_extra_latency <= next_extra;
			asymmetry_adjust   <= next_asym;
			serialiser_latency <= next_serdes;
		end
	end

	// ****************************************************************
	// Read channel
	// ****************************************************************

	logic [`TTC_IDX_W-1:0] ar_idx;
	ttc_pkg::ttc_word_t    read_word;
	logic                  next_arready;
	logic                  next_rvalid;
	ttc_pkg::ttc_word_t    next_rdata;
	logic [1:0]            next_rresp;

	assign ar_idx = araddr[`TTC_ADDR_W-1:2];

	always_comb begin
		unique case (ar_idx)
			`TTC_IDX_REVISION: read_word = `TTC_REVISION_VALUE;
			`TTC_IDX_SCRATCH:  read_word = scratch_test_word;
			`TTC_IDX_NAME0:    read_word = `TTC_NAME0_VALUE;
			`TTC_IDX_NAME1:    read_word = `TTC_NAME1_VALUE;
			`TTC_IDX_NAME2:    read_word = `TTC_NAME2_VALUE;
			`TTC_IDX_PERIOD:   read_word = period_word;
			`TTC_IDX_EXTRA:    read_word = user_extra_latency;
			`TTC_IDX_ASYM:     read_word = 32'(asymmetry_adjust);
			`TTC_IDX_SERDES:   read_word = serialiser_latency;
			default:           read_word = `TTC_WORD_RESET;
		endcase
	end

	always_comb begin
		next_arready = arready;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (rvalid && rready) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
		if (arvalid && arready) begin
			next_rvalid  = 1'b1;
			next_arready = 1'b0;
			next_rdata   = read_word;
			next_rresp   = ttc_mapped(ar_idx) ? ttc_pkg::TTC_RESP_OKAY : ttc_pkg::TTC_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= `TTC_WORD_RESET;
			rresp   <= ttc_pkg::TTC_RESP_OKAY;
		end else begin
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	// ****************************************************************
	// Correction terms for the timestamp datapath
	// ****************************************************************

	// Registered one cycle behind the fields so the datapath sees flop outputs
	// and no long adder chain reaches it from the bus side.
	logic signed [`TTC_DELAY_W-1:0] next_asym_offset;
	logic signed [`TTC_DELAY_W-1:0] next_fixed_delay;

	always_comb begin
		next_asym_offset = ttc_asym(asymmetry_adjust);
		next_fixed_delay = `TTC_DELAY_W'($signed({3'b000, user_extra_latency}))
			+ `TTC_DELAY_W'($signed({3'b000, serialiser_latency}))
			+ next_asym_offset;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			asym_enable    <= 1'b0;
			asym_subtract  <= 1'b0;
			asym_magnitude <= '0;
			asym_offset    <= '0;
			fixed_delay    <= '0;
		end else begin
			asym_enable    <= asymmetry_adjust[`TTC_ASYM_EN_BIT];
			asym_subtract  <= asymmetry_adjust[`TTC_ASYM_SUB_BIT];
			asym_magnitude <= asymmetry_adjust[`TTC_MAG_W-1:0];
			asym_offset    <= next_asym_offset;
			fixed_delay    <= next_fixed_delay;
		end
	end

endmodule : ttc_regs

`default_nettype wire

// File: test/ttc_regs_props.sv
`default_nettype none

// ****************************************************************
// Bus handshake and delay arithmetic checks.
// ****************************************************************
module ttc_regs_props (
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire logic               awvalid,
	input wire logic               awready,
	input wire logic               wvalid,
	input wire logic               wready,
	input wire logic [1:0]         bresp,
	input wire logic               bvalid,
	input wire logic               bready,
	input wire logic               arvalid,
	input wire logic               arready,
	input wire logic [31:0]        rdata,
	input wire logic               rvalid,
	input wire logic               rready,
	input wire logic [31:0]        user_extra_latency,
	input wire logic [31:0]        serialiser_latency,
	input wire logic               asym_enable,
	input wire logic               asym_subtract,
	input wire logic [16:0]        asym_magnitude,
	input wire logic signed [34:0] asym_offset,
	input wire logic signed [34:0] fixed_delay
);
	logic signed [34:0] mag_fix;
	logic signed [34:0] base_sum;

	assign mag_fix  = {2'b00, asym_magnitude, 16'h0000};
	assign base_sum = {3'b000, user_extra_latency} + {3'b000, serialiser_latency};

	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence wr_taken_s;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rd_taken_s;
		arvalid && arready;
	endsequence

	write_answer_a: assert property (wr_taken_s |-> ##2 bvalid)
		else $error("write response not on time");
	write_block_a: assert property (wr_taken_s |=> !awready && !wready)
		else $error("write channel ready while busy");
	read_answer_a: assert property (rd_taken_s |=> rvalid && !arready)
		else $error("read answer not on time");
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	asym_off_a: assert property (!asym_enable |-> asym_offset == 35'sh0)
		else $error("asymmetry applied while disabled");
	asym_sign_a: assert property (asym_enable |-> asym_offset == (asym_subtract ? -mag_fix : mag_fix))
		else $error("asymmetry offset wrong");
	delay_sum_a: assert property (1'b1 |=> fixed_delay == $past(base_sum) + asym_offset)
		else $error("fixed delay sum wrong");
endmodule : ttc_regs_props

bind ttc_regs ttc_regs_props u_props (
	.aclk               (aclk),
	.aresetn            (aresetn),
	.awvalid            (awvalid),
	.awready            (awready),
	.wvalid             (wvalid),
	.wready             (wready),
	.bresp              (bresp),
	.bvalid             (bvalid),
	.bready             (bready),
	.arvalid            (arvalid),
	.arready            (arready),
	.rdata              (rdata),
	.rvalid             (rvalid),
	.rready             (rready),
	.user_extra_latency (user_extra_latency),
	.serialiser_latency (serialiser_latency),
	.asym_enable        (asym_enable),
	.asym_subtract      (asym_subtract),
	.asym_magnitude     (asym_magnitude),
	.asym_offset        (asym_offset),
	.fixed_delay        (fixed_delay)
);

`default_nettype wire

// File: test/ttc_regs_test.sv
`include "ttc_map.svh"

`default_nettype none

module ttc_regs_test;
	timeunit 1ns;
	timeprecision 1ns;

	logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic               awready, wready, bvalid, arready, rvalid, asym_enable, asym_subtract;
	logic [13:0]        awaddr, araddr;
	logic [31:0]        wdata, rdata, user_extra_latency, serialiser_latency;
	logic [3:0]         wstrb;
	logic [1:0]         bresp, rresp;
	logic [19:0]        mac_clock_period;
	logic [16:0]        asym_magnitude;
	logic signed [34:0] asym_offset, fixed_delay, off, exp_d;
	logic [31:0]        ev [13];
	logic [18:0]        aw [3];
	int                 fail_count, n_checks, cyc;

	ttc_regs dut (
		.aclk               (aclk),
		.aresetn            (aresetn),
		.awaddr             (awaddr),
		.awvalid            (awvalid),
		.awready            (awready),
		.wdata              (wdata),
		.wstrb              (wstrb),
		.wvalid             (wvalid),
		.wready             (wready),
		.bresp              (bresp),
		.bvalid             (bvalid),
		.bready             (bready),
		.araddr             (araddr),
		.arvalid            (arvalid),
		.arready            (arready),
		.rdata              (rdata),
		.rresp              (rresp),
		.rvalid             (rvalid),
		.rready             (rready),
		.mac_clock_period   (mac_clock_period),
		.user_extra_latency (user_extra_latency),
		.serialiser_latency (serialiser_latency),
		.asym_enable        (asym_enable),
		.asym_subtract      (asym_subtract),
		.asym_magnitude     (asym_magnitude),
		.asym_offset        (asym_offset),
		.fixed_delay        (fixed_delay)
	);

	// ****************************************************************
	// Compare and bus tasks.
	// ****************************************************************
	task automatic chk_v(input string nm, input logic [34:0] e, input logic [34:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_v

	task automatic chk_r(input string nm, input logic [1:0] e, input logic [1:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_r

	// The response ready is raised only once the answer shows, so the hold checks see a wait.
	task automatic wr(input logic [11:0] i, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		@(posedge aclk);
		awaddr  <= {i, 2'b00};
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if (bvalid) bready <= 1'b1;
		end
		bready <= 1'b0;
		chk_r($sformatf("bresp %h", i), er, bresp);
	endtask : wr

	task automatic rd(input logic [11:0] i, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr  <= {i, 2'b00};
		arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1'b1;
		end
		rready <= 1'b0;
		chk_v($sformatf("rdata %h", i), {3'b000, ed}, {3'b000, rdata});
		chk_r($sformatf("rresp %h", i), er, rresp);
	endtask : rd

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fail_count++;
			conclude();
		end
	end

	// ****************************************************************
	// Tests.
	// ****************************************************************
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		ev = '{`TTC_REVISION_VALUE, 0, `TTC_NAME0_VALUE, `TTC_NAME1_VALUE, `TTC_NAME2_VALUE,
			{12'h000, `TTC_PERIOD_RESET}, 0, 0, 0, 0, 0, 0, 0};
		aw = '{19'h2_0005, 19'h5_FFFF, 19'h6_0003};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int k = 0; k < 13; k++) rd(12'hA00 + 12'(k), ev[k], 2'b00);
		chk_v("period out", {15'h0000, `TTC_PERIOD_RESET}, {15'h0000, mac_clock_period});
		rd(12'hA0D, 32'h0000_0000, 2'b10);
		wr(12'hA0D, 32'hFFFF_FFFF, 4'hF, 2'b10);
		for (int k = 0; k < 10; k += 2) wr(12'hA00 + 12'(k), 32'hFFFF_FFFF, 4'hF, 2'b00);
		for (int k = 0; k < 10; k += 2) rd(12'hA00 + 12'(k), ev[k], 2'b00);
		wr(12'hA01, 32'hA5A5_5A5A, 4'hF, 2'b00);
		wr(12'hA01, 32'h1234_5678, 4'h2, 2'b00);
		rd(12'hA01, 32'hA5A5_565A, 2'b00);
		wr(12'hA05, 32'hFFFF_FFFF, 4'hF, 2'b00);
		rd(12'hA05, 32'h000F_FFFF, 2'b00);
		chk_v("period out", 35'h0_000F_FFFF, {15'h0000, mac_clock_period});
		wr(12'hA0A, 32'h0003_8000, 4'hF, 2'b00);
		wr(12'hA0C, 32'h0012_2395, 4'hF, 2'b00);
		rd(12'hA0A, 32'h0003_8000, 2'b00);
		rd(12'hA0C, 32'h0012_2395, 2'b00);
		chk_v("extra out", {3'b000, 32'h0003_8000}, {3'b000, user_extra_latency});
		chk_v("serialiser out", {3'b000, 32'h0012_2395}, {3'b000, serialiser_latency});
		for (int k = 0; k < 3; k++) begin
			wr(12'hA0B, {13'h1FFF, aw[k]}, 4'hF, 2'b00);
			rd(12'hA0B, {13'h0000, aw[k]}, 2'b00);
			repeat (2) @(posedge aclk);
			off = {2'b00, aw[k][16:0], 16'h0000};
			if (!aw[k][18]) off = '0;
			else if (aw[k][17]) off = -off;
			exp_d = 35'sh0_0003_8000 + 35'sh0_0012_2395 + off;
			chk_v("fixed_delay", exp_d, fixed_delay);
			chk_v("asym fields", {16'h0000, aw[k]}, {16'h0000, asym_enable, asym_subtract, asym_magnitude});
			chk_v("asym_offset", off, asym_offset);
		end
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(12'hA01, 32'h0000_0000, 2'b00);
		rd(12'hA0B, 32'h0000_0000, 2'b00);
		chk_v("period out", {15'h0000, `TTC_PERIOD_RESET}, {15'h0000, mac_clock_period});
		chk_v("serialiser out", 35'h0_0000_0000, {3'b000, serialiser_latency});
		chk_v("fixed_delay", 35'h0_0000_0000, fixed_delay);
		conclude();
	end
endmodule : ttc_regs_test

`default_nettype wire
